// ==== common/sbrg_regs.svh ====
// Purpose: register indices, bit positions and reset values of the rate generator
// Assumes: byte address is four times the register index
// Notes: definitions only
`ifndef SBRG_REGS_SVH
`define SBRG_REGS_SVH
`define SBRG_IDX_POWER_CONTROL_0 8'h87
`define SBRG_IDX_AUX_CONTROL_2 8'ha3
`define SBRG_IDX_S0CTL 8'h98
`define SBRG_IDX_SERIAL0_CONFIG 8'hc0
`define SBRG_IDX_AUX_SERIAL_CONFIG 8'hc1
`define SBRG_IDX_S1CTL 8'hc2
`define SBRG_IDX_RELOAD 8'hc3
`define SBRG_IDX_COUNT 8'hc4
`define SBRG_RST_BYTE 8'h00
`define SBRG_MASK_POWER_CONTROL_0 8'hdf
`define SBRG_MASK_SERIAL0_CONFIG 8'he0
`define SBRG_MASK_AUX_SERIAL_CONFIG 8'h1f
`define SBRG_B_DBL 7
`define SBRG_B_VIEW 6
`define SBRG_B_PD 1
`define SBRG_B_SUBST 7
`define SBRG_B_XDBL 6
`define SBRG_B_M0FAST 5
`define SBRG_B_T1FAST 3
`define SBRG_B_RUN 4
`define SBRG_B_S1DBL 3
`define SBRG_B_FAST 2
`define SBRG_B_CKOE 1
`define SBRG_B_TME 0
`define SBRG_B_REN 4
`define SBRG_B_TB8 3
`define SBRG_B_RB8 2
`define SBRG_B_TI 1
`define SBRG_B_RI 0
`define SBRG_PRESCALE 4'd12
`define SBRG_LOG_M2 3'd6
`define SBRG_LOG_M13 3'd5
`define SBRG_RESP_OK 2'b00
`define SBRG_RESP_ERR 2'b10
`endif

// ==== common/sbrg_pkg.sv ====
// Purpose: shared types of the rate generator
// Assumes: nothing
// Notes: serial mode codes follow the two mode bits
package sbrg_pkg;
  typedef enum logic [1:0] {
    SBRG_M_SHIFT = 2'h0,
    SBRG_M_UART8 = 2'h1,
    SBRG_M_FIXED = 2'h2,
    SBRG_M_UART9 = 2'h3
  } sbrg_mode_t;
endpackage

// ==== hw/sbrg_rate_div.sv ====
// Purpose: power-of-two divider of a source pulse train
// Assumes: i_pulse is a one-cycle pulse on i_mclk
// Notes: a change of i_log restarts nothing; the count in progress is compared with the new terminal count at once
`timescale 1ns/1ps
`default_nettype none
module sbrg_rate_div (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_pulse,
  input wire logic [2:0] i_log,
  output logic o_tick
);
  logic [5:0] cnt_reg;
  logic [5:0] last;
  always_comb begin
    last = 6'((7'h01 << i_log) - 7'h01);
  end
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cnt_reg <= 6'h00;
      o_tick <= 1'b0;
    end else begin
      o_tick <= 1'b0;
      if (i_pulse) begin
        if (cnt_reg >= last) begin
          cnt_reg <= 6'h00;
          o_tick <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + 6'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== hw/sbrg_top.sv ====
// Purpose: rate generator and clock selection for two serial ports
// Assumes: AXI4-Lite master keeps one write and one read outstanding
// Notes: bit ticks are one-cycle enables for the serial shifters
// What this block does
// R01: Primary port rate doubles in modes 1-3 when double-rate bit set.
// R02: Control bit 7 shows framing flag or mode bit; flag always set on error.
// R03: Substitute bit swaps timer 1 overflow for generator overflow while timer 2 is not selected.
// R04: Extra double bit doubles primary rate once more.
// R05: Primary mode 0 shifts at clock/12 or clock/2.
// R06: Timer 1 fast bit clocks timer 1 at full clock, not /12.
// R07: Secondary port has four modes, no framing or address check.
// R08: Both ports run at once with independent modes and rates.
// R09: Clock out toggles on each overflow; overflow pulse feeds peripherals.
// R10: Secondary mode 2 rate is clock/64, doubled by its double bit.
// R11: Secondary modes 1,3 rate is tick/(256-reload)/32, doubled if set.
// R12: Timer mode disables the port and sets transmit flag on overflow.
// R13: Timer mode flags keep interrupting, gated by ninth bit and enable.
// R14: Receive ninth bit picks falling or rising pin edge for the flag.
// R15: In power-down detection is level-based and may wake the processor.
// R16: Timer mode keeps clock supply; clock-out enable masks pin interrupt.
// R17: Counter increments per tick and reloads on overflow.
// R18: Counter runs only while run bit set.
// R19: Fast bit picks clock or clock/12 as counter tick.
// R20: Reload write also loads counter when not in timer mode.
// R21: Stopped counter holds, no overflow, no clock-out toggle.
// R22: Pin is synchronised before edge detection; one edge, one flag.
`timescale 1ns/1ps
`default_nettype none
`include "sbrg_regs.svh"
module sbrg_top import sbrg_pkg::*; (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [11:0] i_axi_awaddr,
  input wire logic i_axi_awvalid,
  output logic o_axi_awready,
  input wire logic [31:0] i_axi_wdata,
  input wire logic [3:0] i_axi_wstrb,
  input wire logic i_axi_wvalid,
  output logic o_axi_wready,
  output logic [1:0] o_axi_bresp,
  output logic o_axi_bvalid,
  input wire logic i_axi_bready,
  input wire logic [11:0] i_axi_araddr,
  input wire logic i_axi_arvalid,
  output logic o_axi_arready,
  output logic [31:0] o_axi_rdata,
  output logic [1:0] o_axi_rresp,
  output logic o_axi_rvalid,
  input wire logic i_axi_rready,
  input wire logic i_timer1_overflow,
  input wire logic i_timer2_selected,
  input wire logic i_framing_error,
  input wire logic i_aux_tx_done,
  input wire logic i_aux_rx_done,
  input wire logic i_aux_irq_enable,
  input wire logic i_aux_rx_pin,
  output logic o_timer1_tick,
  output logic o_uart0_bit_tick,
  output logic o_uart1_bit_tick,
  output logic o_aux_overflow_pulse,
  output logic o_aux_clock_out,
  output logic o_aux_clock_out_oe_n,
  output logic o_aux_irq,
  output logic o_wake
);
  logic [7:0] power_control_0_reg, aux_control_2_reg, serial0_config_reg, aux_serial_config_reg, s1ctl_reg;
  logic [7:0] s0ctl_reg, reload_reg, count_reg;
  logic fe_reg;
  logic [3:0] pre_reg;
  logic tick12, aux_tick, ovf;
  logic aw_hold, w_hold;
  logic [7:0] aw_idx;
  logic aw_hi;
  logic [7:0] wbyte;
  logic wr_go;
  logic [7:0] rd_val;
  logic rd_hit;
  logic rx_s1, rx_s2, rx_s3;
  logic rx_edge, rx_level, rx_set;
  logic tme, run, pd;
  logic [2:0] dbl0, dbl1;
  logic u0_src, u1_src, u0_tick, u1_tick;
  logic [2:0] u0_log, u1_log;
  sbrg_mode_t m0, m1;

  assign tme = aux_serial_config_reg[`SBRG_B_TME];
  assign run = aux_serial_config_reg[`SBRG_B_RUN];
  assign pd = power_control_0_reg[`SBRG_B_PD];
  assign m0 = sbrg_mode_t'({s0ctl_reg[7], s0ctl_reg[6]});
  assign m1 = sbrg_mode_t'(s1ctl_reg[7:6]);

  // Write channels are latched separately so either may come first
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_idx <= 8'h00;
      aw_hi <= 1'b0;
      wbyte <= 8'h00;
      o_axi_bvalid <= 1'b0;
      o_axi_bresp <= `SBRG_RESP_OK;
    end else begin
      if (i_axi_awvalid && o_axi_awready) begin
        aw_hold <= 1'b1;
        aw_idx <= i_axi_awaddr[9:2];
        aw_hi <= |{i_axi_awaddr[11:10], i_axi_awaddr[1:0]};
      end
      if (i_axi_wvalid && o_axi_wready) begin
        w_hold <= 1'b1;
        wbyte <= i_axi_wstrb[0] ? i_axi_wdata[7:0] : 8'h00;
      end
      if (wr_go) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        o_axi_bvalid <= 1'b1;
        o_axi_bresp <= (aw_hi || !rd_hit_w(aw_idx)) ? `SBRG_RESP_ERR : `SBRG_RESP_OK;
      end else if (o_axi_bvalid && i_axi_bready) begin
        o_axi_bvalid <= 1'b0;
      end
    end
  end
  assign o_axi_awready = !aw_hold && !o_axi_bvalid;
  assign o_axi_wready = !w_hold && !o_axi_bvalid;
  assign wr_go = aw_hold && w_hold && !o_axi_bvalid;

  function automatic logic rd_hit_w(input logic [7:0] idx);
    rd_hit_w = (idx == `SBRG_IDX_POWER_CONTROL_0) || (idx == `SBRG_IDX_AUX_CONTROL_2) ||
      (idx == `SBRG_IDX_S0CTL) || (idx == `SBRG_IDX_SERIAL0_CONFIG) ||
      (idx == `SBRG_IDX_AUX_SERIAL_CONFIG) || (idx == `SBRG_IDX_S1CTL) ||
      (idx == `SBRG_IDX_RELOAD) || (idx == `SBRG_IDX_COUNT);
  endfunction

  function automatic logic wr_at(input logic [7:0] idx);
    wr_at = wr_go && !aw_hi && (aw_idx == idx);
  endfunction

  // Lane 0 only carries data; a write without it stores zero
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      power_control_0_reg <= `SBRG_RST_BYTE;
      aux_control_2_reg <= `SBRG_RST_BYTE;
      serial0_config_reg <= `SBRG_RST_BYTE;
      aux_serial_config_reg <= `SBRG_RST_BYTE;
      reload_reg <= `SBRG_RST_BYTE;
    end else begin
      if (wr_at(`SBRG_IDX_POWER_CONTROL_0)) power_control_0_reg <= wbyte & `SBRG_MASK_POWER_CONTROL_0;
      if (wr_at(`SBRG_IDX_AUX_CONTROL_2)) aux_control_2_reg <= wbyte;
      if (wr_at(`SBRG_IDX_SERIAL0_CONFIG)) serial0_config_reg <= wbyte & `SBRG_MASK_SERIAL0_CONFIG;
      if (wr_at(`SBRG_IDX_AUX_SERIAL_CONFIG)) aux_serial_config_reg <= wbyte & `SBRG_MASK_AUX_SERIAL_CONFIG;
      if (wr_at(`SBRG_IDX_RELOAD)) reload_reg <= wbyte;
    end
  end

  // Bit 7 of the primary control is two bits sharing one address
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      s0ctl_reg <= `SBRG_RST_BYTE;
      fe_reg <= 1'b0;
    end else begin
      if (wr_at(`SBRG_IDX_S0CTL)) begin
        s0ctl_reg[6:0] <= wbyte[6:0];
        if (!power_control_0_reg[`SBRG_B_VIEW]) s0ctl_reg[7] <= wbyte[7]; // R02
      end
      if (i_framing_error) begin
        fe_reg <= 1'b1; // R02
      end else if (wr_at(`SBRG_IDX_S0CTL) && power_control_0_reg[`SBRG_B_VIEW]) begin
        fe_reg <= wbyte[7];
      end
    end
  end

  // Flags: a hardware set in the clearing cycle wins
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      s1ctl_reg <= `SBRG_RST_BYTE;
    end else begin
      if (wr_at(`SBRG_IDX_S1CTL)) s1ctl_reg <= wbyte;
      if (tme ? ovf : i_aux_tx_done) s1ctl_reg[`SBRG_B_TI] <= 1'b1; // R12
      if (tme ? rx_set : i_aux_rx_done) s1ctl_reg[`SBRG_B_RI] <= 1'b1; // R13
    end
  end

  always_comb begin
    rd_hit = !(|{i_axi_araddr[11:10], i_axi_araddr[1:0]}) && rd_hit_w(i_axi_araddr[9:2]);
    unique case (i_axi_araddr[9:2])
      `SBRG_IDX_POWER_CONTROL_0: rd_val = power_control_0_reg;
      `SBRG_IDX_AUX_CONTROL_2: rd_val = aux_control_2_reg;
      `SBRG_IDX_S0CTL: rd_val = {power_control_0_reg[`SBRG_B_VIEW] ? fe_reg : s0ctl_reg[7],
                                 s0ctl_reg[6:0]}; // R02
      `SBRG_IDX_SERIAL0_CONFIG: rd_val = serial0_config_reg;
      `SBRG_IDX_AUX_SERIAL_CONFIG: rd_val = aux_serial_config_reg;
      `SBRG_IDX_S1CTL: rd_val = s1ctl_reg;
      `SBRG_IDX_RELOAD: rd_val = reload_reg;
      `SBRG_IDX_COUNT: rd_val = count_reg;
      default: rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_axi_rvalid <= 1'b0;
      o_axi_rdata <= 32'h0000_0000;
      o_axi_rresp <= `SBRG_RESP_OK;
    end else if (i_axi_arvalid && o_axi_arready) begin
      o_axi_rvalid <= 1'b1;
      o_axi_rdata <= {24'h00_0000, rd_hit ? rd_val : 8'h00};
      o_axi_rresp <= rd_hit ? `SBRG_RESP_OK : `SBRG_RESP_ERR;
    end else if (o_axi_rvalid && i_axi_rready) begin
      o_axi_rvalid <= 1'b0;
    end
  end
  assign o_axi_arready = !o_axi_rvalid;

  // Free-running divide-by-12 shared by every slow clock selection
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      pre_reg <= 4'h0;
    end else begin
      pre_reg <= (pre_reg == `SBRG_PRESCALE - 4'd1) ? 4'h0 : pre_reg + 4'h1;
    end
  end
  assign tick12 = (pre_reg == `SBRG_PRESCALE - 4'd1);
  assign aux_tick = aux_serial_config_reg[`SBRG_B_FAST] ? 1'b1 : tick12; // R19
  assign ovf = run && aux_tick && (count_reg == 8'hff); // R18 R21

  // Software access to the counter wins over the count in that cycle
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      count_reg <= `SBRG_RST_BYTE;
    end else if (wr_at(`SBRG_IDX_COUNT)) begin
      count_reg <= wbyte;
    end else if (wr_at(`SBRG_IDX_RELOAD) && !tme) begin
      count_reg <= wbyte; // R20
    end else if (ovf) begin
      count_reg <= reload_reg; // R17
    end else if (run && aux_tick) begin
      count_reg <= count_reg + 8'h01; // R17 R18
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_aux_overflow_pulse <= 1'b0;
      o_aux_clock_out <= 1'b0;
      o_aux_clock_out_oe_n <= 1'b1;
    end else begin
      o_aux_overflow_pulse <= ovf; // R09 R16
      if (ovf) o_aux_clock_out <= !o_aux_clock_out; // R09 R21
      o_aux_clock_out_oe_n <= !aux_serial_config_reg[`SBRG_B_CKOE]; // R16
    end
  end

  // Pin synchroniser; only rx_s2 onward is looked at
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      rx_s3 <= 1'b1;
    end else begin
      rx_s1 <= i_aux_rx_pin; // R22
      rx_s2 <= rx_s1;
      rx_s3 <= rx_s2;
    end
  end
  assign rx_edge = s1ctl_reg[`SBRG_B_RB8] ? (rx_s2 && !rx_s3) : (!rx_s2 && rx_s3); // R14
  assign rx_level = s1ctl_reg[`SBRG_B_RB8] ? rx_s2 : !rx_s2; // R15
  assign rx_set = tme && s1ctl_reg[`SBRG_B_REN] && (pd ? rx_level : rx_edge); // R14 R15

  // Pin-change interrupt is masked while the pin carries the clock
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_aux_irq <= 1'b0;
      o_wake <= 1'b0;
    end else begin
      o_aux_irq <= (s1ctl_reg[`SBRG_B_TI] && (!tme || s1ctl_reg[`SBRG_B_TB8])) ||
        (s1ctl_reg[`SBRG_B_RI] && (!tme || (s1ctl_reg[`SBRG_B_REN] &&
        !aux_serial_config_reg[`SBRG_B_CKOE]))); // R13 R16
      o_wake <= pd && rx_set && i_aux_irq_enable && !aux_serial_config_reg[`SBRG_B_CKOE]; // R15
    end
  end

  // Each doubling removes one stage of the power-of-two divider
  assign dbl0 = {2'b00, power_control_0_reg[`SBRG_B_DBL]} + {2'b00, serial0_config_reg[`SBRG_B_XDBL]}; // R01 R04
  assign dbl1 = {2'b00, aux_serial_config_reg[`SBRG_B_S1DBL]};
  always_comb begin
    u0_src = 1'b1;
    u0_log = `SBRG_LOG_M2 - dbl0; // R01 R04
    if (m0 == SBRG_M_UART8 || m0 == SBRG_M_UART9) begin
      u0_log = `SBRG_LOG_M13 - dbl0;
      u0_src = (serial0_config_reg[`SBRG_B_SUBST] && !i_timer2_selected) ? ovf
        : i_timer1_overflow; // R03
    end
    u1_src = 1'b1;
    u1_log = `SBRG_LOG_M2 - dbl1; // R10
    if (m1 == SBRG_M_UART8 || m1 == SBRG_M_UART9) begin
      u1_log = `SBRG_LOG_M13 - dbl1; // R11
      u1_src = ovf;
    end
  end

  sbrg_rate_div u_div0 (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_pulse(u0_src),
    .i_log(u0_log),
    .o_tick(u0_tick)
  );
  sbrg_rate_div u_div1 (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_pulse(u1_src),
    .i_log(u1_log),
    .o_tick(u1_tick)
  );

  // Mode 0 bypasses the dividers; timer mode silences the second port
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_uart0_bit_tick <= 1'b0;
      o_uart1_bit_tick <= 1'b0;
      o_timer1_tick <= 1'b0;
    end else begin
      o_timer1_tick <= aux_control_2_reg[`SBRG_B_T1FAST] ? 1'b1 : tick12; // R06
      if (m0 == SBRG_M_SHIFT) begin
        o_uart0_bit_tick <= serial0_config_reg[`SBRG_B_M0FAST] ? pre_reg[0] : tick12; // R05
      end else begin
        o_uart0_bit_tick <= u0_tick; // R08
      end
      if (tme) begin
        o_uart1_bit_tick <= 1'b0; // R12
      end else if (m1 == SBRG_M_SHIFT) begin
        o_uart1_bit_tick <= tick12; // R07
      end else begin
        o_uart1_bit_tick <= u1_tick; // R08
      end
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  property p_reload;
    ovf && !wr_go |=> count_reg == $past(reload_reg);
  endproperty
  a_reload: assert property (p_reload) else $error("no reload on overflow"); // R17
  property p_toggle;
    ovf |=> o_aux_clock_out != $past(o_aux_clock_out) && o_aux_overflow_pulse;
  endproperty
  a_toggle: assert property (p_toggle) else $error("clock out missed toggle"); // R09
  property p_stopped;
    !run && !wr_go |=> $stable(count_reg) && !o_aux_overflow_pulse;
  endproperty
  a_stopped: assert property (p_stopped) else $error("stopped counter moved"); // R21
  property p_ti;
    tme && ovf |=> s1ctl_reg[`SBRG_B_TI];
  endproperty
  a_ti: assert property (p_ti) else $error("overflow flag not set"); // R12
  property p_fe;
    i_framing_error |=> fe_reg;
  endproperty
  a_fe: assert property (p_fe) else $error("framing flag lost"); // R02
  property p_fast;
    run && aux_serial_config_reg[`SBRG_B_FAST] && !wr_go && count_reg != 8'hff
      |=> count_reg == $past(count_reg) + 8'h01;
  endproperty
  a_fast: assert property (p_fast) else $error("fast tick missed"); // R19
  property p_slow;
    !aux_serial_config_reg[`SBRG_B_FAST] && !tick12 && !wr_go |=> $stable(count_reg);
  endproperty
  a_slow: assert property (p_slow) else $error("slow tick too fast"); // R19
  property p_load;
    wr_at(`SBRG_IDX_RELOAD) && !tme |=> count_reg == reload_reg;
  endproperty
  a_load: assert property (p_load) else $error("reload write missed counter"); // R20
  property p_once;
    rx_set && !pd |=> !rx_set;
  endproperty
  a_once: assert property (p_once) else $error("edge seen twice"); // R22
  property p_irq;
    tme && s1ctl_reg[`SBRG_B_TI] && s1ctl_reg[`SBRG_B_TB8] |=> o_aux_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("timer interrupt missing"); // R13
  c_ovf: cover property (ovf ##[1:300] ovf);
  c_rx: cover property (rx_set && !pd);
  c_wake: cover property (o_wake);
  c_sub: cover property (serial0_config_reg[`SBRG_B_SUBST] && o_uart0_bit_tick);
endmodule
`default_nettype wire

// ==== dv/sbrg_far_model.sv ====
// Purpose: far side of the rate generator: timer 1 and secondary shifter
// Assumes: ticks are one-cycle enables on i_mclk
// Notes: timer 1 overflows every fourth count; a frame ends after ten bit ticks
`timescale 1ns/1ps
`default_nettype none
module sbrg_far_model (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_timer1_tick,
  input wire logic i_bit_tick,
  input wire logic i_send,
  output logic o_timer1_overflow,
  output logic o_tx_done
);
  logic [1:0] t1_reg;
  logic [3:0] bit_reg;
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      t1_reg <= 2'h0;
      o_timer1_overflow <= 1'b0;
    end else begin
      o_timer1_overflow <= i_timer1_tick && (t1_reg == 2'h3);
      if (i_timer1_tick) t1_reg <= t1_reg + 2'h1;
    end
  end
  // Start, eight data and stop bit make one frame
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      bit_reg <= 4'h0;
      o_tx_done <= 1'b0;
    end else begin
      o_tx_done <= i_send && i_bit_tick && (bit_reg == 4'h9);
      if (!i_send) bit_reg <= 4'h0;
      else if (i_bit_tick) bit_reg <= (bit_reg == 4'h9) ? 4'h0 : bit_reg + 4'h1;
    end
  end
endmodule
`default_nettype wire

// ==== dv/test_serial_baud_rate_generator.sv ====
// Purpose: self-checking bench of the serial rate generator
// Assumes: register byte address is four times the index
// Notes: rates are judged by counting ticks over whole periods
`timescale 1ns/1ps
`default_nettype none
`include "sbrg_regs.svh"
module test_serial_baud_rate_generator;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic fe = 1'b0, irq_en = 1'b0, rx = 1'b1, send = 1'b0;
  logic awr, wr, bv, arr, rv, t1ov, txd, t1t, u0t, u1t, ovp, cko, oe_n, irq, wake;
  logic [1:0] br, rr, r;
  logic [31:0] rdat;
  logic [7:0] d;
  int n_errors = 0;
  int checked = 0;
  int c_t1, c_u0, c_u1, c_ov, c_ck;
  sbrg_top dut_u (
    .i_mclk(clk), .i_rst(rst), .i_axi_awaddr(awaddr), .i_axi_awvalid(awv),
    .o_axi_awready(awr), .i_axi_wdata(wdata), .i_axi_wstrb(4'hf), .i_axi_wvalid(wv),
    .o_axi_wready(wr), .o_axi_bresp(br), .o_axi_bvalid(bv), .i_axi_bready(bready),
    .i_axi_araddr(araddr), .i_axi_arvalid(arv), .o_axi_arready(arr), .o_axi_rdata(rdat),
    .o_axi_rresp(rr), .o_axi_rvalid(rv), .i_axi_rready(rready), .i_timer1_overflow(t1ov),
    .i_timer2_selected(1'b0), .i_framing_error(fe), .i_aux_tx_done(txd),
    .i_aux_rx_done(1'b0), .i_aux_irq_enable(irq_en), .i_aux_rx_pin(rx),
    .o_timer1_tick(t1t), .o_uart0_bit_tick(u0t), .o_uart1_bit_tick(u1t),
    .o_aux_overflow_pulse(ovp), .o_aux_clock_out(cko), .o_aux_clock_out_oe_n(oe_n),
    .o_aux_irq(irq), .o_wake(wake)
  );
  sbrg_far_model far_u (
    .i_mclk(clk), .i_rst(rst), .i_timer1_tick(t1t), .i_bit_tick(u1t), .i_send(send),
    .o_timer1_overflow(t1ov), .o_tx_done(txd)
  );
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic hang(input string m);
    n_errors++;
    $display("wrong value at %0t: %s timed out", $time, m);
    conclude();
  endtask
  // Address and data offered together, each released once taken
  task automatic wr8(input logic [7:0] idx, input logic [7:0] v);
    int k;
    @(posedge clk);
    awaddr <= {2'h0, idx, 2'h0};
    wdata <= {24'h0, v};
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
      if (bv) break;
    end
    if (k == 40) hang("write");
    r = br;
    bready <= 1'b0;
  endtask
  task automatic wrk(input logic [7:0] idx, input logic [7:0] v);
    wr8(idx, v);
    chk(r, `SBRG_RESP_OK, "bresp");
  endtask
  task automatic rd8(input logic [7:0] idx);
    int k;
    @(posedge clk);
    araddr <= {2'h0, idx, 2'h0};
    arv <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
      if (rv) break;
    end
    if (k == 40) hang("read");
    d = rdat[7:0];
    r = rr;
    rready <= 1'b0;
  endtask
  task automatic rdm(input logic [7:0] idx, input logic [7:0] mk, input logic [7:0] e,
                     input string m);
    rd8(idx);
    chk(d & mk, e, m);
  endtask
  // Settles first so a divider change cannot leave a short period in the window
  task automatic meas(input int n);
    logic ck0;
    repeat (130) @(posedge clk);
    ck0 = cko;
    c_t1 = 0;
    c_u0 = 0;
    c_u1 = 0;
    c_ov = 0;
    c_ck = 0;
    repeat (n) begin
      @(posedge clk);
      if (t1t === 1'b1) c_t1++;
      if (u0t === 1'b1) c_u0++;
      if (u1t === 1'b1) c_u1++;
      if (ovp === 1'b1) c_ov++;
      if (cko !== ck0) c_ck++;
      ck0 = cko;
    end
  endtask
  task automatic t_reset();
    logic [7:0] ids [8] = '{`SBRG_IDX_POWER_CONTROL_0, `SBRG_IDX_AUX_CONTROL_2, `SBRG_IDX_S0CTL,
      `SBRG_IDX_SERIAL0_CONFIG, `SBRG_IDX_AUX_SERIAL_CONFIG, `SBRG_IDX_S1CTL, `SBRG_IDX_RELOAD, `SBRG_IDX_COUNT};
    for (int i = 0; i < 8; i++) rdm(ids[i], 8'hff, `SBRG_RST_BYTE, "reset");
    chk(oe_n, 1, "pin off");
    rd8(8'h01);
    chk(r, `SBRG_RESP_ERR, "unmapped read");
    wr8(8'h01, 8'h55);
    chk(r, `SBRG_RESP_ERR, "unmapped write");
    wrk(`SBRG_IDX_AUX_SERIAL_CONFIG, 8'he0);
    rdm(`SBRG_IDX_AUX_SERIAL_CONFIG, 8'hff, 8'h00, "reserved");
    $display("t_reset done");
  endtask
  task automatic t_count();
    wrk(`SBRG_IDX_RELOAD, 8'h5a);
    rdm(`SBRG_IDX_COUNT, 8'hff, 8'h5a, "load");
    meas(50);
    chk(c_ov, 0, "stopped");
    chk(c_ck, 0, "stopped clock");
    rdm(`SBRG_IDX_COUNT, 8'hff, 8'h5a, "hold");
    wrk(`SBRG_IDX_RELOAD, 8'hfc);
    wrk(`SBRG_IDX_AUX_SERIAL_CONFIG, 8'h14);
    meas(40);
    chk(c_ov, 10, "fast");
    chk(c_ck, 10, "toggle");
    wrk(`SBRG_IDX_AUX_SERIAL_CONFIG, 8'h10);
    wrk(`SBRG_IDX_RELOAD, 8'hff);
    meas(120);
    chk(c_ov, 10, "slow");
    wrk(`SBRG_IDX_AUX_SERIAL_CONFIG, 8'h04);
    meas(48);
    chk(c_ov, 0, "run off");
    $display("t_count done");
  endtask
  task automatic t_rates();
    logic [7:0] pc [3] = '{8'h00, 8'h80, 8'h80};
    logic [7:0] sc [3] = '{8'h00, 8'h00, 8'h40};
    logic [7:0] s1 [3] = '{8'h10, 8'h18, 8'h18};
    int e0 [3] = '{10, 20, 40};
    int e1 [3] = '{10, 20, 20};
    meas(120);
    chk(c_u0, 10, "mode 0 slow");
    chk(c_t1, 10, "timer 1 slow");
    wrk(`SBRG_IDX_AUX_CONTROL_2, 8'h08);
    wrk(`SBRG_IDX_SERIAL0_CONFIG, 8'h20);
    meas(120);
    chk(c_u0, 60, "mode 0 fast");
    chk(c_t1, 120, "timer 1 fast");
    wrk(`SBRG_IDX_SERIAL0_CONFIG, 8'h00);
    wrk(`SBRG_IDX_S0CTL, 8'h40);
    meas(640);
    chk(c_u0, 5, "timer 1 source");
    wrk(`SBRG_IDX_SERIAL0_CONFIG, 8'h80);
    wrk(`SBRG_IDX_AUX_SERIAL_CONFIG, 8'h14);
    wrk(`SBRG_IDX_S1CTL, 8'h40);
    send <= 1'b1;
    meas(320);
    send <= 1'b0;
    chk(c_u1, 10, "secondary mode 1");
    chk(c_u0, 10, "substitute");
    rdm(`SBRG_IDX_S1CTL, 8'h02, 8'h02, "frame sent");
    wrk(`SBRG_IDX_AUX_SERIAL_CONFIG, 8'h1c);
    meas(320);
    chk(c_u1, 20, "secondary double");
    chk(c_u0, 10, "primary unchanged");
    wrk(`SBRG_IDX_S0CTL, 8'h80);
    wrk(`SBRG_IDX_S1CTL, 8'h80);
    for (int i = 0; i < 3; i++) begin
      wrk(`SBRG_IDX_POWER_CONTROL_0, pc[i]);
      wrk(`SBRG_IDX_SERIAL0_CONFIG, sc[i]);
      wrk(`SBRG_IDX_AUX_SERIAL_CONFIG, s1[i]);
      meas(640);
      chk(c_u0, e0[i], "primary mode 2");
      chk(c_u1, e1[i], "secondary mode 2");
    end
    $display("t_rates done");
  endtask
  task automatic t_timer();
    wrk(`SBRG_IDX_S1CTL, 8'h00);
    wrk(`SBRG_IDX_AUX_SERIAL_CONFIG, 8'h00);
    wrk(`SBRG_IDX_RELOAD, 8'h77);
    wrk(`SBRG_IDX_AUX_SERIAL_CONFIG, 8'h01);
    wrk(`SBRG_IDX_RELOAD, 8'h33);
    rdm(`SBRG_IDX_COUNT, 8'hff, 8'h77, "no load");
    wrk(`SBRG_IDX_RELOAD, 8'hf0);
    wrk(`SBRG_IDX_AUX_SERIAL_CONFIG, 8'h15);
    meas(64);
    chk(c_ov, 4, "timer supply");
    rdm(`SBRG_IDX_S1CTL, 8'h03, 8'h02, "overflow flag");
    chk(irq, 0, "gated");
    wrk(`SBRG_IDX_S1CTL, 8'h08);
    // The write clears the flag; wait one full overflow period for it to return
    repeat (20) @(posedge clk);
    chk(irq, 1, "ungated");
    wrk(`SBRG_IDX_AUX_SERIAL_CONFIG, 8'h17);
    repeat (4) @(posedge clk);
    chk(oe_n, 0, "pin on");
    $display("t_timer done");
  endtask
  task automatic t_rx();
    wrk(`SBRG_IDX_AUX_SERIAL_CONFIG, 8'h11);
    wrk(`SBRG_IDX_S1CTL, 8'h10);
    rx <= 1'b0;
    repeat (8) @(posedge clk);
    rdm(`SBRG_IDX_S1CTL, 8'h01, 8'h01, "fall");
    chk(irq, 1, "pin irq");
    wrk(`SBRG_IDX_S1CTL, 8'h10);
    rdm(`SBRG_IDX_S1CTL, 8'h01, 8'h00, "once");
    rx <= 1'b1;
    repeat (8) @(posedge clk);
    rdm(`SBRG_IDX_S1CTL, 8'h01, 8'h00, "rise ignored");
    wrk(`SBRG_IDX_S1CTL, 8'h14);
    rx <= 1'b0;
    repeat (8) @(posedge clk);
    rdm(`SBRG_IDX_S1CTL, 8'h01, 8'h00, "fall ignored");
    rx <= 1'b1;
    repeat (8) @(posedge clk);
    rdm(`SBRG_IDX_S1CTL, 8'h01, 8'h01, "rise");
    wrk(`SBRG_IDX_AUX_SERIAL_CONFIG, 8'h13);
    repeat (4) @(posedge clk);
    chk(irq, 0, "masked");
    wrk(`SBRG_IDX_AUX_SERIAL_CONFIG, 8'h11);
    wrk(`SBRG_IDX_S1CTL, 8'h10);
    irq_en <= 1'b1;
    wrk(`SBRG_IDX_POWER_CONTROL_0, 8'h02);
    rx <= 1'b0;
    repeat (8) @(posedge clk);
    chk(wake, 1, "wake");
    wrk(`SBRG_IDX_S1CTL, 8'h10);
    rdm(`SBRG_IDX_S1CTL, 8'h01, 8'h01, "level");
    rx <= 1'b1;
    irq_en <= 1'b0;
    wrk(`SBRG_IDX_POWER_CONTROL_0, 8'h00);
    $display("t_rx done");
  endtask
  task automatic t_frame();
    wrk(`SBRG_IDX_S0CTL, 8'h00);
    fe <= 1'b1;
    @(posedge clk);
    fe <= 1'b0;
    rdm(`SBRG_IDX_S0CTL, 8'h80, 8'h00, "mode view");
    wrk(`SBRG_IDX_POWER_CONTROL_0, 8'h40);
    rdm(`SBRG_IDX_S0CTL, 8'h80, 8'h80, "flag view");
    $display("t_frame done");
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_count();
    t_rates();
    t_timer();
    t_rx();
    t_frame();
    conclude();
  end
  initial begin
    #2000000;
    hang("run");
  end
endmodule
`default_nettype wire
